/* File: design/address_generation_unit.sv */
`timescale 1ns/1ps
`include "agu_consts.svh"
// Operation
// - Index mode: base register plus index register
// - Index shifted left by access-size scale
// - Unsigned 32-bit add, carry discarded
// - Immediate pre/post increment and decrement
// - Immediate increment wraps on overflow
// - Immediate decrement wraps on underflow
// - Push and pop take step from 8-bit immediate, not size
// - Register modify pre/post by index register
// - Access base plus short offset, add index
// - Sixteenth register is the stack pointer
// - Stack grows up; pointer at next empty
// - Call, return, interrupt fault unless 8-aligned
// - Misaligned stack access faults, any mode
// - Every pointer access checked for alignment
// - Stack-relative: pointer minus thirteen-bit immediate
// - Push stores at pointer, then adds step
// - Pop subtracts step, then loads there
// - Call stores return address, pointer plus eight
// - Return loads return address, pointer minus eight
// - Two loads, one store; one write per register
module address_generation_unit
  import agu_pkg::*;
(
  // Clock and reset
  input  wire logic      clk,
  input  wire logic      rst_n,
  // Packet: two load slots and one store slot
  input  wire logic      ld0Valid,
  input  wire agu_op_e   ld0Op,
  input  wire acc_size_e ld0Size,
  input  wire reg_sel_t  ld0Base,
  input  wire reg_sel_t  ld0Index,
  input  wire word_t     ld0Imm,
  input  wire logic      ld1Valid,
  input  wire agu_op_e   ld1Op,
  input  wire acc_size_e ld1Size,
  input  wire reg_sel_t  ld1Base,
  input  wire reg_sel_t  ld1Index,
  input  wire word_t     ld1Imm,
  input  wire logic      stValid,
  input  wire agu_op_e   stOp,
  input  wire acc_size_e stSize,
  input  wire reg_sel_t  stBase,
  input  wire reg_sel_t  stIndex,
  input  wire word_t     stImm,
  input  wire word_t     stData,
  // Call, return and interrupt entry
  input  wire word_t     returnAddressValue,
  input  wire logic      intEntry,
  // Address register load from the datapath
  input  wire logic      aregWrEn,
  input  wire reg_sel_t  aregWrSel,
  input  wire word_t     aregWrData,
  // Memory side
  output logic          ld0Req,
  output word_t         ld0Addr,
  output acc_size_e     ld0SizeOut,
  output logic          ld1Req,
  output word_t         ld1Addr,
  output acc_size_e     ld1SizeOut,
  output logic          stReq,
  output word_t         stAddr,
  output acc_size_e     stSizeOut,
  output logic [63:0]   stWrData,
  // Status
  output logic          addrFault,
  output logic          writeConflict,
  output word_t         stackPointerReg
);

  // -----------------------------------------------------------------
  // Slots
  // -----------------------------------------------------------------
  agu_req_if slot [3] ();
  word_t     regs [`AGU_NUM_AREGS];
  logic      slotV [3];
  agu_op_e   slotOp [3];
  acc_size_e slotSz [3];
  reg_sel_t  slotB [3];
  reg_sel_t  slotI [3];
  word_t     slotImm [3];
  logic      entryBad;

  typedef struct packed
  {
    logic        ld0Req;
    word_t       ld0Addr;
    acc_size_e   ld0Size;
    logic        ld1Req;
    word_t       ld1Addr;
    acc_size_e   ld1Size;
    logic        stReq;
    word_t       stAddr;
    acc_size_e   stSize;
    logic [63:0] stData;
    logic        fault;
    logic        conflict;
  } state_s;

  state_s st_q;
  state_s st_d;
  logic   anyFault;
  logic   conflict;
  logic [3:0] wrEnVec;
  reg_sel_t   wrSelVec [4];
  word_t      wrDataVec [4];

  always_comb
  begin
    // Load slot 0
    slotV[0]   = ld0Valid;
    slotOp[0]  = ld0Op;
    slotSz[0]  = ld0Size;
    slotB[0]   = ld0Base;
    slotI[0]   = ld0Index;
    slotImm[0] = ld0Imm;
    // Load slot 1
    slotV[1]   = ld1Valid;
    slotOp[1]  = ld1Op;
    slotSz[1]  = ld1Size;
    slotB[1]   = ld1Base;
    slotI[1]   = ld1Index;
    slotImm[1] = ld1Imm;
    // Store slot
    slotV[2]   = stValid;
    slotOp[2]  = stOp;
    slotSz[2]  = stSize;
    slotB[2]   = stBase;
    slotI[2]   = stIndex;
    slotImm[2] = stImm;
  end

  for (genvar s = 0; s < 3; s++)
  begin : g_slot
    assign slot[s].valid    = slotV[s];
    assign slot[s].op       = slotOp[s];
    // Call and return move a full 64-bit stack slot
    assign slot[s].size     = (slotOp[s] == OP_CALL || slotOp[s] == OP_RETURN) ?
                              SIZE_64 : slotSz[s];
    assign slot[s].baseSel  = slotB[s];
    assign slot[s].indexSel = slotI[s];
    assign slot[s].imm      = slotImm[s];
    assign slot[s].isStore  = (s == 2);

    agu_slot_calc u_calc
    (
      .req      (slot[s]),
      .baseVal  (regs[slotB[s]]),
      .indexVal (regs[slotI[s]]),
      .spVal    (regs[`AGU_SP_INDEX])
    );

    assign wrEnVec[s]   = slot[s].wrEn;
    assign wrSelVec[s]  = slot[s].wrSel;
    assign wrDataVec[s] = slot[s].wrData;
  end

  // -----------------------------------------------------------------
  // Interrupt entry alignment and write checks
  // -----------------------------------------------------------------
  assign entryBad = intEntry && (|(regs[`AGU_SP_INDEX][2:0] & `AGU_FRAME_ALIGN));

  always_comb
  begin
    conflict = 1'b0;
    for (int a = 0; a < 4; a++)
    begin
      for (int b = a + 1; b < 4; b++)
      begin
        if (wrEnVec[a] && wrEnVec[b] && wrSelVec[a] == wrSelVec[b])
        begin
          conflict = 1'b1;
        end
      end
    end
  end

  assign wrEnVec[3]   = aregWrEn;
  assign wrSelVec[3]  = aregWrSel;
  assign wrDataVec[3] = aregWrData;

  assign anyFault = slot[0].fault || slot[1].fault || slot[2].fault || entryBad;

  // -----------------------------------------------------------------
  // Register file; a faulting or conflicting packet writes nothing
  // -----------------------------------------------------------------
  logic [3:0] commitEn;
  assign commitEn = (anyFault || conflict) ? 4'h0 : wrEnVec;

  agu_areg_file u_regs
  (
    .clk    (clk),
    .rst_n  (rst_n),
    .wrEn   (commitEn),
    .wrSel  (wrSelVec),
    .wrData (wrDataVec),
    .regs   (regs)
  );

  // -----------------------------------------------------------------
  // Output registers
  // -----------------------------------------------------------------
  always_comb
  begin
    st_d          = st_q;
    st_d.fault    = anyFault;
    st_d.conflict = conflict;
    st_d.ld0Req   = slot[0].addrValid && !anyFault && !conflict;
    st_d.ld0Addr  = slot[0].addr;
    st_d.ld0Size  = slot[0].size;
    st_d.ld1Req   = slot[1].addrValid && !anyFault && !conflict;
    st_d.ld1Addr  = slot[1].addr;
    st_d.ld1Size  = slot[1].size;
    st_d.stReq    = slot[2].addrValid && !anyFault && !conflict;
    st_d.stAddr   = slot[2].addr;
    st_d.stSize   = slot[2].size;
    st_d.stData   = (stOp == OP_CALL) ? {32'h0000_0000, returnAddressValue} :
                    {32'h0000_0000, stData};
    if (stOp != OP_CALL && stSize == SIZE_64)
    begin
      st_d.stData = {stData, stData};
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign ld0Req          = st_q.ld0Req;
  assign ld0Addr         = st_q.ld0Addr;
  assign ld0SizeOut      = st_q.ld0Size;
  assign ld1Req          = st_q.ld1Req;
  assign ld1Addr         = st_q.ld1Addr;
  assign ld1SizeOut      = st_q.ld1Size;
  assign stReq           = st_q.stReq;
  assign stAddr          = st_q.stAddr;
  assign stSizeOut       = st_q.stSize;
  assign stWrData        = st_q.stData;
  assign addrFault       = st_q.fault;
  assign writeConflict   = st_q.conflict;
  assign stackPointerReg = regs[`AGU_SP_INDEX];

endmodule : address_generation_unit

/* File: design/agu_areg_file.sv */
`timescale 1ns/1ps
`include "agu_consts.svh"
// Sixteen address registers; last one is the stack pointer
module agu_areg_file
  import agu_pkg::*;
(
  // Clock and reset
  input  wire logic     clk,
  input  wire logic     rst_n,
  // Write ports, one per slot plus one external
  input  wire logic [3:0] wrEn,
  input  wire reg_sel_t   wrSel [4],
  input  wire word_t      wrData [4],
  // Contents
  output word_t           regs [`AGU_NUM_AREGS]
);

  typedef struct packed
  {
    word_t [`AGU_NUM_AREGS-1:0] a;
  } state_s;

  state_s st_q;
  state_s st_d;

  always_comb
  begin
    st_d = st_q;
    for (int p = 0; p < 4; p++)
    begin
      if (wrEn[p])
      begin
        st_d.a[wrSel[p]] = wrData[p];
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  for (genvar i = 0; i < `AGU_NUM_AREGS; i++)
  begin : g_out
    assign regs[i] = st_q.a[i];
  end

endmodule : agu_areg_file

/* File: design/agu_consts.svh */
`ifndef AGU_CONSTS_SVH
`define AGU_CONSTS_SVH
// Register file shape
`define AGU_NUM_AREGS      16
`define AGU_SP_INDEX       4'hF
`define AGU_AREG_RESET     32'h0000_0000
// Stack frame step for call and return; frame alignment for call, return and interrupt entry
`define AGU_FRAME_STEP     32'h0000_0008
`define AGU_FRAME_ALIGN    3'h7
// Stack-relative reach in bytes (13-bit offset field)
`define AGU_STACK_REACH    8192
`define AGU_STACK_OFF_W    13
`define AGU_SHORT_OFF_W    7
`define AGU_STEP_IMM_W     8
`endif

/* File: design/agu_pkg.sv */
package agu_pkg;

  // Access width: byte, 16, 32, 64 bit
  typedef enum logic [1:0]
  {
    SIZE_8,
    SIZE_16,
    SIZE_32,
    SIZE_64
  } acc_size_e;

  // Addressing operations handled by this unit
  typedef enum logic [3:0]
  {
    OP_NONE,
    OP_INDEX,
    OP_PRE_INC_IMM,
    OP_POST_INC_IMM,
    OP_PRE_DEC_IMM,
    OP_POST_DEC_IMM,
    OP_PRE_INC_REG,
    OP_POST_INC_REG,
    OP_PRE_DEC_REG,
    OP_POST_DEC_REG,
    OP_OFFSET_INC_REG,
    OP_STACK_REL,
    OP_PUSH,
    OP_POP,
    OP_CALL,
    OP_RETURN
  } agu_op_e;

  typedef logic [31:0] word_t;
  typedef logic [3:0]  reg_sel_t;

endpackage : agu_pkg

/* File: design/agu_req_if.sv */
`timescale 1ns/1ps
// One memory-access slot request from decode and its generated address
interface agu_req_if;
  import agu_pkg::*;
  logic      valid;
  agu_op_e   op;
  acc_size_e size;
  reg_sel_t  baseSel;
  reg_sel_t  indexSel;
  word_t     imm;
  logic      isStore;
  logic      addrValid;
  word_t     addr;
  logic      fault;
  logic      wrEn;
  reg_sel_t  wrSel;
  word_t     wrData;

  modport src
  (
    output valid, op, size, baseSel, indexSel, imm, isStore,
    input  addrValid, addr, fault, wrEn, wrSel, wrData
  );
  modport gen
  (
    input  valid, op, size, baseSel, indexSel, imm, isStore,
    output addrValid, addr, fault, wrEn, wrSel, wrData
  );
endinterface : agu_req_if

/* File: design/agu_slot_calc.sv */
`timescale 1ns/1ps
`include "agu_consts.svh"
// Combinational address calculation for one access slot
module agu_slot_calc
  import agu_pkg::*;
(
  // Request and result
  agu_req_if.gen  req,
  // Register file read values
  input  wire word_t baseVal,
  input  wire word_t indexVal,
  input  wire word_t spVal
);

  word_t     step;
  logic [1:0] scale;
  word_t     scaledIdx;
  word_t     preAddr;
  logic      misaligned;
  logic      frameBad;

  always_comb
  begin
    // ---------------------------------------------------------------
    // Step and scale from access width
    // ---------------------------------------------------------------
    scale     = req.size;
    step      = 32'h0000_0001 << scale;
    scaledIdx = indexVal << scale;
    req.addr  = baseVal;
    req.wrEn  = 1'b0;
    req.wrSel = req.baseSel;
    req.wrData = baseVal;
    frameBad  = 1'b0;
    preAddr   = baseVal;
    unique case (req.op)
      OP_NONE:
      begin
        req.addr = baseVal;
      end
      OP_INDEX:
      begin
        req.addr = baseVal + scaledIdx;
      end
      OP_PRE_INC_IMM, OP_POST_INC_IMM:
      begin
        req.wrEn   = 1'b1;
        req.wrData = baseVal + req.imm;
        req.addr   = (req.op == OP_PRE_INC_IMM) ? req.wrData : baseVal;
      end
      OP_PRE_DEC_IMM, OP_POST_DEC_IMM:
      begin
        req.wrEn   = 1'b1;
        req.wrData = baseVal - req.imm;
        req.addr   = (req.op == OP_PRE_DEC_IMM) ? req.wrData : baseVal;
      end
      OP_PRE_INC_REG, OP_POST_INC_REG:
      begin
        req.wrEn   = 1'b1;
        req.wrData = baseVal + indexVal;
        req.addr   = (req.op == OP_PRE_INC_REG) ? req.wrData : baseVal;
      end
      OP_PRE_DEC_REG, OP_POST_DEC_REG:
      begin
        req.wrEn   = 1'b1;
        req.wrData = baseVal - indexVal;
        req.addr   = (req.op == OP_PRE_DEC_REG) ? req.wrData : baseVal;
      end
      OP_OFFSET_INC_REG:
      begin
        req.addr   = baseVal + {25'h0, req.imm[`AGU_SHORT_OFF_W-1:0]};
        req.wrEn   = 1'b1;
        req.wrData = baseVal + indexVal;
      end
      OP_STACK_REL:
      begin
        req.addr = spVal - {19'h0, req.imm[`AGU_STACK_OFF_W-1:0]};
      end
      OP_PUSH:
      begin
        req.addr   = spVal;
        req.wrEn   = 1'b1;
        req.wrSel  = `AGU_SP_INDEX;
        req.wrData = spVal + {24'h0, req.imm[`AGU_STEP_IMM_W-1:0]};
      end
      OP_POP:
      begin
        preAddr    = spVal - {24'h0, req.imm[`AGU_STEP_IMM_W-1:0]};
        req.addr   = preAddr;
        req.wrEn   = 1'b1;
        req.wrSel  = `AGU_SP_INDEX;
        req.wrData = preAddr;
      end
      OP_CALL:
      begin
        req.addr   = spVal;
        req.wrEn   = 1'b1;
        req.wrSel  = `AGU_SP_INDEX;
        req.wrData = spVal + `AGU_FRAME_STEP;
        frameBad   = |(spVal[2:0] & `AGU_FRAME_ALIGN);
      end
      OP_RETURN:
      begin
        preAddr    = spVal - `AGU_FRAME_STEP;
        req.addr   = preAddr;
        req.wrEn   = 1'b1;
        req.wrSel  = `AGU_SP_INDEX;
        req.wrData = preAddr;
        frameBad   = |(spVal[2:0] & `AGU_FRAME_ALIGN);
      end
    endcase
    // ---------------------------------------------------------------
    // Alignment check on every generated address
    // ---------------------------------------------------------------
    misaligned    = |(req.addr & (step - 32'h0000_0001));
    req.fault     = req.valid && (misaligned || frameBad);
    req.addrValid = req.valid && (req.op != OP_NONE);
    if (!req.valid || req.fault)
    begin
      req.wrEn = 1'b0;
    end
  end

endmodule : agu_slot_calc

/* File: sim/address_generation_unit_tb_top.sv */
`timescale 1ns/1ps
module address_generation_unit_tb_top
  import agu_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        v [3];
  agu_op_e     o [3];
  acc_size_e   z [3];
  reg_sel_t    b [3];
  reg_sel_t    x [3];
  word_t       m [3];
  word_t       stData, retAddr, wrData, base, idx, got;
  logic        intEntry, aregWrEn, ld0Req, ld1Req, stReq, addrFault, writeConflict;
  reg_sel_t    wrSel;
  word_t       ld0Addr, ld1Addr, stAddr, stackPointerReg;
  acc_size_e   sz;
  logic [63:0] stWrData, rdData, e;
  int          n_mismatch = 0;
  int          checks = 0;
  word_t       seed = 32'h1A09;

  always #20 clk = ~clk;

  address_generation_unit i_dut
  (
    .clk, .rst_n, .ld0Valid(v[0]), .ld0Op(o[0]), .ld0Size(z[0]), .ld0Base(b[0]),
    .ld0Index(x[0]), .ld0Imm(m[0]), .ld1Valid(v[1]), .ld1Op(o[1]), .ld1Size(z[1]),
    .ld1Base(b[1]), .ld1Index(x[1]), .ld1Imm(m[1]), .stValid(v[2]), .stOp(o[2]),
    .stSize(z[2]), .stBase(b[2]), .stIndex(x[2]), .stImm(m[2]), .stData,
    .returnAddressValue(retAddr), .intEntry, .aregWrEn, .aregWrSel(wrSel),
    .aregWrData(wrData), .ld0Req, .ld0Addr, .ld0SizeOut(), .ld1Req, .ld1Addr,
    .ld1SizeOut(), .stReq, .stAddr, .stSizeOut(), .stWrData, .addrFault, .writeConflict,
    .stackPointerReg
  );

  agu_mem_model i_mem
  (
    .clk, .stReq, .stAddr, .stWrData, .ld0Req, .ld0Addr, .rdData
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [159:0] g, input logic [159:0] ex);
    checks++;
    if (g !== ex)
    begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, ex);
      n_mismatch++;
    end
  endtask : chk

  task automatic stop_test();
    if (n_mismatch == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test

  function automatic word_t rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // Expected {new register, access address} of a pre/post inc/dec
  function automatic logic [63:0] modExp(input word_t bs, input word_t st, input int k);
    word_t nv;
    nv = (k < 2) ? bs + st : bs - st;
    return {nv, (k % 2 == 0) ? nv : bs};
  endfunction : modExp

  task automatic set(input int s, input agu_op_e op, input acc_size_e sa, input reg_sel_t bs,
                     input reg_sel_t ix, input word_t im);
    v[s] = 1'b1;
    o[s] = op;
    z[s] = sa;
    b[s] = bs;
    x[s] = ix;
    m[s] = im;
  endtask : set

  // One packet: taken at the next rising edge, results checked at the falling edge
  task automatic go();
    @(negedge clk);
    v = '{default: 1'b0};
    intEntry = 1'b0;
    aregWrEn = 1'b0;
  endtask : go

  task automatic wr(input reg_sel_t s, input word_t d);
    aregWrEn = 1'b1;
    wrSel = s;
    wrData = d;
    go();
  endtask : wr

  // Register 1 is never written, so it serves as a zero index
  task automatic peek(input reg_sel_t s);
    set(0, OP_INDEX, SIZE_8, s, 4'h1, 32'h0);
    go();
    got = ld0Addr;
  endtask : peek

  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    stop_test();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    v = '{default: 1'b0};
    o = '{default: OP_NONE};
    z = '{default: SIZE_8};
    b = '{default: 4'h0};
    x = '{default: 4'h0};
    m = '{default: 32'h0};
    {stData, retAddr, wrData, wrSel, intEntry, aregWrEn} = '0;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    chk({ld0Req, stReq, addrFault, stackPointerReg}, 35'h0);
    for (int i = 0; i < 24; i++)
    begin
      sz = acc_size_e'(rnd() & 32'h3);
      base = rnd() & ~((32'h1 << sz) - 32'h1);
      idx = rnd();
      wr(4'h2, base);
      wr(4'h0, idx);
      set(0, OP_INDEX, sz, 4'h2, 4'h0, 32'h0);
      go();
      chk({ld0Req, ld0Addr}, {1'b1, base + (idx << sz)});
    end
    wr(4'h2, 32'h101);
    set(0, OP_INDEX, SIZE_32, 4'h2, 4'h1, 32'h0);
    go();
    chk({addrFault, ld0Req}, 2'b10);
    for (int md = 0; md < 2; md++)
      for (int k = 0; k < 4; k++)
        for (int s = 0; s < 4; s++)
        begin
          sz = acc_size_e'(s);
          base = (k < 2) ? 32'hFFFF_FFF8 : 32'h0;
          e = modExp(base, 32'h1 << s, k);
          wr(4'h2, base);
          wr(4'h0, 32'h1 << s);
          set(0, agu_op_e'((md ? OP_PRE_INC_REG : OP_PRE_INC_IMM) + k), sz, 4'h2, 4'h0,
              32'h1 << s);
          go();
          chk({ld0Req, ld0Addr}, {1'b1, e[31:0]});
          peek(4'h2);
          chk(got, e[63:32]);
        end
    wr(4'h0, 32'h40);
    wr(4'h2, 32'h200);
    set(0, OP_OFFSET_INC_REG, SIZE_8, 4'h2, 4'h0, 32'hFFFF_FF95);
    go();
    chk({ld0Req, ld0Addr}, {1'b1, 32'h215});
    peek(4'h2);
    chk(got, 32'h240);
    set(0, OP_POST_INC_IMM, SIZE_32, 4'h2, 4'h0, 32'h4);
    set(1, OP_PRE_DEC_IMM, SIZE_32, 4'h2, 4'h0, 32'h4);
    go();
    chk({writeConflict, ld0Req, ld1Req}, 3'b100);
    set(0, OP_INDEX, SIZE_32, 4'h2, 4'h1, 32'h0);
    set(1, OP_INDEX, SIZE_32, 4'h2, 4'h1, 32'h0);
    go();
    chk({writeConflict, ld0Req, ld1Req, ld0Addr, ld1Addr}, {3'b011, 32'h240, 32'h240});
    wr(4'hF, 32'h1000);
    chk(stackPointerReg, 32'h1000);
    stData = 32'hA5C3_0F17;
    set(2, OP_PUSH, SIZE_64, 4'hF, 4'h0, 32'h110);
    go();
    chk({stReq, stAddr, stackPointerReg, stWrData}, {1'b1, 64'h1000_0000_1010, stData, stData});
    set(0, OP_POP, SIZE_64, 4'hF, 4'h0, 32'h10);
    go();
    chk({ld0Req, ld0Addr, stackPointerReg}, {1'b1, 64'h1000_0000_1000});
    @(negedge clk);
    chk(rdData, {stData, stData});
    set(0, OP_STACK_REL, SIZE_32, 4'hF, 4'h0, 32'hE008);
    go();
    chk({ld0Req, ld0Addr}, {1'b1, 32'h0FF8});
    set(0, OP_STACK_REL, SIZE_64, 4'hF, 4'h0, 32'h4);
    go();
    chk({addrFault, ld0Req}, 2'b10);
    retAddr = 32'h0000_2468;
    set(2, OP_CALL, SIZE_32, 4'hF, 4'h0, 32'h0);
    go();
    chk({stReq, stAddr, stackPointerReg, stWrData}, {1'b1, 64'h1000_0000_1008, 32'h0, retAddr});
    set(0, OP_RETURN, SIZE_32, 4'hF, 4'h0, 32'h0);
    go();
    chk({ld0Req, ld0Addr, stackPointerReg}, {1'b1, 64'h1000_0000_1000});
    @(negedge clk);
    chk(rdData[31:0], retAddr);
    wr(4'hF, 32'h1004);
    set(2, OP_CALL, SIZE_32, 4'hF, 4'h0, 32'h0);
    go();
    chk({addrFault, stReq, stackPointerReg}, {2'b10, 32'h1004});
    set(0, OP_RETURN, SIZE_32, 4'hF, 4'h0, 32'h0);
    go();
    chk({addrFault, ld0Req, stackPointerReg}, {2'b10, 32'h1004});
    intEntry = 1'b1;
    go();
    chk(addrFault, 1'b1);
    wr(4'hF, 32'h1008);
    intEntry = 1'b1;
    go();
    chk(addrFault, 1'b0);
    stop_test();
  end
endmodule : address_generation_unit_tb_top

/* File: sim/agu_asserts.sv */
`timescale 1ns/1ps
module agu_asserts
  import agu_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // Slot requests
  input wire logic        ld0Valid,
  input wire agu_op_e     ld0Op,
  input wire reg_sel_t    ld0Base,
  input wire word_t       ld0Imm,
  input wire logic        ld1Valid,
  input wire agu_op_e     ld1Op,
  input wire reg_sel_t    ld1Base,
  input wire logic        stValid,
  input wire agu_op_e     stOp,
  input wire word_t       stImm,
  input wire word_t       returnAddressValue,
  // Memory side and status
  input wire logic        ld0Req,
  input wire word_t       ld0Addr,
  input wire logic        ld1Req,
  input wire logic        stReq,
  input wire word_t       stAddr,
  input wire logic [63:0] stWrData,
  input wire logic        addrFault,
  input wire logic        writeConflict,
  input wire word_t       stackPointerReg
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  chk_pop_addr:
    assert property (ld0Valid && ld0Op == OP_POP |=> ld0Req |-> ld0Addr == stackPointerReg
      && stackPointerReg == $past(stackPointerReg) - {24'h0, $past(ld0Imm[7:0])})
    else $error("pop address wrong");
  chk_push_addr:
    assert property (stValid && stOp == OP_PUSH |=> stReq |-> stAddr == $past(stackPointerReg)
      && stackPointerReg == $past(stackPointerReg) + {24'h0, $past(stImm[7:0])})
    else $error("push address wrong");
  chk_call_frame:
    assert property (stValid && stOp == OP_CALL |=> stReq |-> stAddr == $past(stackPointerReg)
      && stackPointerReg == $past(stackPointerReg) + 32'h8
      && stWrData == {32'h0, $past(returnAddressValue)})
    else $error("call frame wrong");
  chk_ret_frame:
    assert property (ld0Valid && ld0Op == OP_RETURN |=> ld0Req |->
      stackPointerReg == $past(stackPointerReg) - 32'h8 && ld0Addr == stackPointerReg)
    else $error("return frame wrong");
  chk_stack_rel:
    assert property (ld0Valid && ld0Op == OP_STACK_REL |=> ld0Req |->
      ld0Addr == $past(stackPointerReg) - {19'h0, $past(ld0Imm[12:0])})
    else $error("stack relative address wrong");
  chk_call_fault:
    assert property (stValid && stOp == OP_CALL && stackPointerReg[2:0] != 3'h0
      |=> addrFault && !stReq)
    else $error("misaligned call not refused");
  chk_write_twice:
    assert property (ld0Valid && ld1Valid && ld0Base == ld1Base
      && ld0Op inside {[OP_PRE_INC_IMM:OP_OFFSET_INC_REG]}
      && ld1Op inside {[OP_PRE_INC_IMM:OP_OFFSET_INC_REG]} |=> writeConflict && !ld0Req)
    else $error("double write not flagged");
  chk_refused_quiet:
    assert property (addrFault || writeConflict |-> !ld0Req && !ld1Req && !stReq)
    else $error("request issued with fault");

  cover property (stValid && stOp == OP_CALL ##1 stReq);
  cover property (ld0Valid && ld0Op == OP_POP ##1 ld0Req);
  cover property (writeConflict);
endmodule : agu_asserts

bind address_generation_unit agu_asserts i_chk
(
  .clk, .rst_n, .ld0Valid, .ld0Op, .ld0Base, .ld0Imm, .ld1Valid, .ld1Op, .ld1Base,
  .stValid, .stOp, .stImm, .returnAddressValue, .ld0Req, .ld0Addr, .ld1Req, .stReq,
  .stAddr, .stWrData, .addrFault, .writeConflict, .stackPointerReg
);

/* File: sim/agu_mem_model.sv */
`timescale 1ns/1ps
// Data memory behind the store slot and load slot 0
module agu_mem_model
  import agu_pkg::*;
(
  // Clock
  input  wire logic        clk,
  // Requests
  input  wire logic        stReq,
  input  wire word_t       stAddr,
  input  wire logic [63:0] stWrData,
  input  wire logic        ld0Req,
  input  wire word_t       ld0Addr,
  // Load data one cycle after the request
  output logic [63:0]      rdData
);
  logic [63:0] mem [word_t];

  initial rdData = 64'h0;
  always @(posedge clk)
  begin
    if (stReq)
      mem[stAddr] = stWrData;
    // Idle or unknown location: data bus flips so stale data never matches
    if (ld0Req && mem.exists(ld0Addr))
      rdData <= mem[ld0Addr];
    else
      rdData <= ~rdData;
  end
endmodule : agu_mem_model
